// file: src/lia_top.v
`include "lia_consts.vh"
// interrupt aggregator for a multi-channel line unit
module lia_top #(
  parameter NCH = 9,
  parameter TICK_CYC = `LIA_TICK_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire [NCH-1:0] chan_sw_reset,
  // channel events, eight bits per channel per group
  input wire [NCH*8-1:0] live_in0,
  input wire [NCH*8-1:0] live_in1,
  input wire [NCH*8-1:0] event_in0,
  input wire [NCH*8-1:0] event_in2,
  // host controls
  input wire [NCH*8-1:0] edge_select_reg,
  input wire [NCH*3-1:0] mask_wr_en,
  input wire [23:0] mask_wr_data,
  input wire [NCH*24-1:0] clear_wr,
  input wire gcf_wr_en,
  input wire [7:0] gcf_wr_data,
  input wire tick_clear,
  // status outputs
  output reg [NCH*8-1:0] live_status_flat,
  output reg [NCH*24-1:0] latched_status_flat,
  output reg [NCH*24-1:0] mask_flat,
  output reg [7:0] global_config_reg,
  output reg second_tick_latched,
  output reg [NCH-1:0] channel_pending_regs,
  output reg irq_n
);
  wire [NCH-1:0] pend;
  wire [NCH*16-1:0] live_w;
  wire [NCH*24-1:0] lat_w;
  wire [NCH*24-1:0] msk_w;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  wire global_irq_mask = global_config_reg[`LIA_GCF_GLB_MASK_BIT];
  wire second_tick_mask = global_config_reg[`LIA_GCF_TICK_MASK_BIT];

  // ----------------------------------------
  // channels
  // ----------------------------------------
  // nineteen sources per channel here, the global tick below [RULE1]
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      lia_chan u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .chan_sw_reset(chan_sw_reset[i]),
        .live_in0(live_in0[i*8+7:i*8]),
        .live_in1(live_in1[i*8+7:i*8]),
        .event_in0(event_in0[i*8+7:i*8]),
        .event_in2(event_in2[i*8+7:i*8]),
        .edge_select_reg(edge_select_reg[i*8+7:i*8]),
        .mask_wr_en({5'b00000, mask_wr_en[i*3+2:i*3]}),
        .mask_wr_data(mask_wr_data),
        .clear_wr(clear_wr[i*24+23:i*24]),
        .live_status_reg0(live_w[i*16+7:i*16]),
        .live_status_reg1(live_w[i*16+15:i*16+8]),
        .latched_status_reg0(lat_w[i*24+7:i*24]),
        .latched_status_reg1(lat_w[i*24+15:i*24+8]),
        .latched_status_reg2(lat_w[i*24+23:i*24+16]),
        .mask_reg0(msk_w[i*24+7:i*24]),
        .mask_reg1(msk_w[i*24+15:i*24+8]),
        .mask_reg2(msk_w[i*24+23:i*24+16]),
        .pend(pend[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // one-second timer on master clock
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC - 1) begin
      tick_cnt_r <= 32'h00000000; // [RULE17]
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // global config, timer status, outputs
  // ----------------------------------------
  integer k;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_config_reg <= `LIA_GCF_RST; // [RULE18]
      second_tick_latched <= 1'b0;
      channel_pending_regs <= {NCH{1'b0}};
      irq_n <= 1'b1;
      live_status_flat <= {NCH*8{1'b0}};
      latched_status_flat <= {NCH*24{1'b0}};
      mask_flat <= {NCH*24{1'b1}};
    end else begin
      if (gcf_wr_en) global_config_reg <= gcf_wr_data; // [RULE5]
      // tick sets even if clear in same cycle [RULE16] [RULE8]
      second_tick_latched <= (second_tick_latched & ~tick_clear) | tick_r;
      // summary gated by global mask too [RULE7] [RULE9]
      channel_pending_regs <= pend & {NCH{~global_irq_mask}};
      // pin low while anything unmasked is pending [RULE6] [RULE10]
      irq_n <= ~(~global_irq_mask & ((|pend) | (second_tick_latched & ~second_tick_mask)));
      latched_status_flat <= lat_w;
      mask_flat <= msk_w;
      for (k = 0; k < NCH; k = k + 1) begin
        live_status_flat[k*8 +: 8] <= live_w[k*16+8 +: 8]; // reg1 live (inband, sync)
      end
    end
  end
endmodule // lia_top

// file: common/lia_consts.vh
// How it works
// [RULE1] twenty sources: nineteen per channel, one global timer source
// [RULE2] sources one to ten have live status bits read while condition present; live_status_flat carries only the reg1 live bits
// [RULE3] edge select picks rising only or both edges to set latched status
// [RULE4] sources eleven to twenty set latched status directly on their event
// [RULE5] each source has its own mask; global config bit 1 masks all
// [RULE6] any unmasked latched event drives the active-low interrupt pin
// [RULE7] unmasked channel event sets that channel's summary bit
// [RULE8] writing one clears a latched status bit; zero writes are ignored
// [RULE9] channel summary stays set until every pending channel event is cleared
// [RULE10] interrupt pin goes inactive only once all pending events are cleared
// [RULE11] inband codes: live bits 1 and 0, shared edge select bit 0
// [RULE12] pattern sync uses bit 5 of live, edge, latched and mask registers
// [RULE13] rx jitter fifo fault sets latched reg0 bit 5, mask reg0 bit 5
// [RULE14] tx jitter fifo fault sets latched reg0 bit 6, mask reg0 bit 6
// [RULE15] error counter overflow sets latched reg2 bit 0, mask reg2 bit 0
// [RULE16] second tick sets timer status bit 0, masked by global config bit 0
// [RULE17] one-second timer counts the master clock
// [RULE18] device reset sets every mask so all sources start masked
// [RULE19] channel software reset masks only that channel's sources
// [RULE20] masks gate pin and summary only; latching still happens while masked
// [RULE21] live inputs sampled on master clock; edges against previous sample
`ifndef LIA_CONSTS_VH
`define LIA_CONSTS_VH
// ----------------------------------------
// register field positions
// ----------------------------------------
`define LIA_GCF_TICK_MASK_BIT 0
`define LIA_GCF_GLB_MASK_BIT 1
`define LIA_INB_DEACT_BIT 0
`define LIA_INB_ACT_BIT 1
`define LIA_INB_EDGE_BIT 0
`define LIA_PSYNC_BIT 5
`define LIA_RXJA_BIT 5
`define LIA_TXJA_BIT 6
`define LIA_CNTOV_BIT 0
`define LIA_TICK_BIT 0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define LIA_MASK_RST 8'hFF
`define LIA_GCF_RST 8'h03
`define LIA_EDGE_RST 8'h00
`define LIA_CLK_HZ 20000000
`define LIA_TICK_S 1
`define LIA_TICK_CYC (`LIA_CLK_HZ * `LIA_TICK_S)
`endif

// file: src/lia_chan.v
`include "lia_consts.vh"
// one channel: live sampling, edge rules, latching, masking
module lia_chan (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire chan_sw_reset,
  // raw events
  input wire [7:0] live_in0,
  input wire [7:0] live_in1,
  input wire [7:0] event_in0,
  input wire [7:0] event_in2,
  // host controls
  input wire [7:0] edge_select_reg,
  input wire [7:0] mask_wr_en,
  input wire [23:0] mask_wr_data,
  input wire [23:0] clear_wr,
  // state
  output wire [7:0] live_status_reg0,
  output wire [7:0] live_status_reg1,
  output reg [7:0] latched_status_reg0,
  output reg [7:0] latched_status_reg1,
  output reg [7:0] latched_status_reg2,
  output reg [7:0] mask_reg0,
  output reg [7:0] mask_reg1,
  output reg [7:0] mask_reg2,
  output wire pend
);
  reg [15:0] sync1_r;
  reg [15:0] sync2_r;
  reg [15:0] prev_r;
  wire [15:0] rise;
  wire [15:0] fall;
  wire [15:0] both_sel;
  wire [7:0] set0;
  wire [7:0] set1;
  wire [7:0] set2;

  // ----------------------------------------
  // live status sampling
  // ----------------------------------------
  // two-stage sync then previous-sample edge compare
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      prev_r <= 16'h0000;
    end else begin
      sync1_r <= {live_in1, live_in0}; // [RULE21]
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  assign live_status_reg0 = sync2_r[7:0] & 8'h1F; // [RULE2]
  assign live_status_reg1 = sync2_r[15:8] & 8'hE3; // [RULE2] [RULE11] [RULE12]
  assign rise = sync2_r & ~prev_r; // [RULE21]
  assign fall = ~sync2_r & prev_r;
  // edge select per source; shared selects for los, ais, inband pairs
  assign both_sel = {edge_select_reg[6], edge_select_reg[6], edge_select_reg[5], 3'b000,
    edge_select_reg[`LIA_INB_EDGE_BIT], edge_select_reg[`LIA_INB_EDGE_BIT], // [RULE11]
    3'b000, edge_select_reg[4], edge_select_reg[3], edge_select_reg[2],
    edge_select_reg[1], edge_select_reg[1]};
  wire [15:0] edge_hit = rise | (fall & both_sel); // [RULE3] [RULE12]
  assign set0 = {event_in0[7:5], edge_hit[4:0]}; // [RULE4] [RULE13] [RULE14]
  assign set1 = edge_hit[15:8] & 8'hE3;
  assign set2 = event_in2 & 8'h3F; // [RULE4] [RULE15]

  // ----------------------------------------
  // latched status, set beats clear
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latched_status_reg0 <= 8'h00;
      latched_status_reg1 <= 8'h00;
      latched_status_reg2 <= 8'h00;
    end else begin
      // set regardless of mask [RULE20]; write-one clears [RULE8]
      latched_status_reg0 <= (latched_status_reg0 & ~clear_wr[7:0]) | set0;
      latched_status_reg1 <= (latched_status_reg1 & ~clear_wr[15:8]) | set1;
      latched_status_reg2 <= (latched_status_reg2 & ~clear_wr[23:16]) | set2;
    end
  end

  // ----------------------------------------
  // masks
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg0 <= `LIA_MASK_RST; // [RULE18]
      mask_reg1 <= `LIA_MASK_RST;
      mask_reg2 <= `LIA_MASK_RST;
    end else if (chan_sw_reset) begin
      mask_reg0 <= `LIA_MASK_RST; // [RULE19]
      mask_reg1 <= `LIA_MASK_RST;
      mask_reg2 <= `LIA_MASK_RST;
    end else begin
      if (mask_wr_en[0]) mask_reg0 <= mask_wr_data[7:0]; // [RULE5]
      if (mask_wr_en[1]) mask_reg1 <= mask_wr_data[15:8];
      if (mask_wr_en[2]) mask_reg2 <= mask_wr_data[23:16];
    end
  end

  // pending while any unmasked latched bit remains [RULE9]
  assign pend = |(latched_status_reg0 & ~mask_reg0) | |(latched_status_reg1 & ~mask_reg1) |
    |(latched_status_reg2 & ~mask_reg2); // [RULE7]
endmodule // lia_chan

// file: dv/lia_checker_sva.sv
module lia_checker #(parameter NCH = 9) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // inputs
  input wire logic [NCH-1:0] chan_sw_reset,
  input wire logic [NCH*8-1:0] live_in1,
  input wire logic [NCH*8-1:0] event_in2,
  input wire logic [NCH*24-1:0] clear_wr,
  // outputs
  input wire logic [NCH*24-1:0] latched_status_flat,
  input wire logic [NCH*24-1:0] mask_flat,
  input wire logic [7:0] global_config_reg,
  input wire logic second_tick_latched,
  input wire logic [NCH-1:0] channel_pending_regs,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // one edge after release the flat copies show the channel masks
  a_reset_masks_set: assert property ($fell(rst) |=> &mask_flat && irq_n)
    else $error("masks not set");
  a_pin_idle_clear: assert property (
    (~|latched_status_flat && !second_tick_latched) [*2] |-> irq_n)
    else $error("pin low while idle");
  // global mask seen one edge on, channel mask two edges on (flat copy lag)
  a_event_pin_low: assert property (
    event_in2[0] ##1 !global_config_reg[1] ##1 !mask_flat[16]
      |-> !irq_n && channel_pending_regs[0])
    else $error("pin not raised");
  a_masked_latch_sets: assert property (event_in2[0] |-> ##2 latched_status_flat[16])
    else $error("event not latched");
  a_zero_write_keeps: assert property (
    latched_status_flat[16] && !$past(clear_wr[16]) |=> latched_status_flat[16])
    else $error("bit lost");
  a_clear_drops_bit: assert property (
    clear_wr[16] && !event_in2[0] |-> ##2 !latched_status_flat[16])
    else $error("bit not cleared");
  a_live_rise_latch: assert property (
    $rose(live_in1[5]) |-> ##4 latched_status_flat[13])
    else $error("rise not latched");
  a_tick_pin_low: assert property (
    second_tick_latched && global_config_reg[1:0] == 2'b00 |=> !irq_n)
    else $error("tick did not drive pin");
  a_chan_reset_mask: assert property (chan_sw_reset[0] |-> ##2 &mask_flat[23:0])
    else $error("channel masks not set");
  c_pin_low: cover property (!irq_n);
  c_summary_drop: cover property ($fell(channel_pending_regs[0]));
  c_tick: cover property ($rose(second_tick_latched));
endmodule // lia_checker

// file: dv/lia_host_model.sv
module lia_host_model #(parameter N = 2) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin and status
  input wire logic irq_n,
  input wire logic host_auto,
  input wire logic second_tick_latched,
  input wire logic [N*24-1:0] tb_clr,
  input wire logic [N*24-1:0] latched_status_flat,
  // clear strobes
  output logic [N*24-1:0] clear_wr,
  output logic tick_clear
);
  timeunit 1ns;
  timeprecision 100ps;
  // service the pin by writing ones back, else pass bench clears
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clear_wr <= '0;
      tick_clear <= 1'b0;
    end else begin
      clear_wr <= (host_auto && !irq_n) ? latched_status_flat : tb_clr;
      tick_clear <= host_auto && !irq_n && second_tick_latched;
    end
  end
endmodule // lia_host_model

// file: dv/line_unit_interrupt_aggregator_test.sv
module line_unit_interrupt_aggregator_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 2;
  logic clk_sys = 0, rst = 1, gcf_wr_en = 0, host_auto = 0;
  logic tick_clear, irq_n, second_tick_latched;
  logic [N-1:0] chan_sw_reset = 0, channel_pending_regs;
  logic [N*8-1:0] live_in0 = 0, live_in1 = 0, event_in0 = 0, event_in2 = 0;
  logic [N*8-1:0] edge_select_reg = 0, live_status_flat;
  logic [N*3-1:0] mask_wr_en = 0;
  logic [23:0] mask_wr_data = 0;
  logic [N*24-1:0] clear_wr, tb_clr = 0, latched_status_flat, mask_flat;
  logic [7:0] gcf_wr_data = 0, global_config_reg;
  logic [47:0] tab [5] = '{48'h20, 48'h40, 48'h80, 48'h0100_0000_0000, 48'h2000_0000_0000};
  int mismatches = 0, n_compared = 0;
  // --------
  // clock, design, host
  // --------
  always #25 clk_sys = ~clk_sys;
  lia_top #(.NCH(N), .TICK_CYC(20)) u_lia_top (
    .clk_sys(clk_sys), .rst(rst), .chan_sw_reset(chan_sw_reset), .live_in0(live_in0),
    .live_in1(live_in1), .event_in0(event_in0), .event_in2(event_in2),
    .edge_select_reg(edge_select_reg), .mask_wr_en(mask_wr_en), .mask_wr_data(mask_wr_data),
    .clear_wr(clear_wr), .gcf_wr_en(gcf_wr_en), .gcf_wr_data(gcf_wr_data),
    .tick_clear(tick_clear), .live_status_flat(live_status_flat),
    .latched_status_flat(latched_status_flat), .mask_flat(mask_flat),
    .global_config_reg(global_config_reg), .second_tick_latched(second_tick_latched),
    .channel_pending_regs(channel_pending_regs), .irq_n(irq_n)
  );
  lia_host_model #(.N(N)) u_lia_host_model (
    .clk_sys(clk_sys), .rst(rst), .irq_n(irq_n), .host_auto(host_auto),
    .second_tick_latched(second_tick_latched), .tb_clr(tb_clr),
    .latched_status_flat(latched_status_flat), .clear_wr(clear_wr), .tick_clear(tick_clear)
  );
  // --------
  // tasks
  // --------
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ev(logic [15:0] a, logic [15:0] b);
    @(posedge clk_sys);
    event_in0 <= a;
    event_in2 <= b;
    @(posedge clk_sys);
    event_in0 <= '0;
    event_in2 <= '0;
    cyc(2);
  endtask
  task automatic clr(logic [47:0] v);
    @(posedge clk_sys);
    tb_clr <= v;
    @(posedge clk_sys);
    tb_clr <= '0;
    cyc(3);
  endtask
  task automatic gw(logic [7:0] d);
    @(posedge clk_sys);
    gcf_wr_en <= 1'b1;
    gcf_wr_data <= d;
    @(posedge clk_sys);
    gcf_wr_en <= 1'b0;
    cyc(2);
  endtask
  task automatic lv(logic [15:0] a, logic [15:0] b);
    @(posedge clk_sys);
    live_in0 <= a;
    live_in1 <= b;
    cyc(6);
  endtask
  task automatic wt(bit s, logic v, int b);
    while ((s ? second_tick_latched : irq_n) !== v) begin
      if (b-- == 0) begin
        mismatches++;
        $display("Error %s expected %b seen %b", s ? "second_tick_latched" : "irq_n", v,
          s ? second_tick_latched : irq_n);
        tally_and_finish();
      end else begin
        cyc(1);
      end
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    chk("mask_flat", '1, mask_flat);
    chk("gcf", 8'h03, global_config_reg);
    ev(16'h0000, 16'h0001);
    chk("masked latch", 48'h10000, latched_status_flat);
    chk("masked pin", 1'b1, irq_n);
    clr(48'h10000);
    chk("cleared", 48'h0, latched_status_flat);
    gw(8'h01);
    @(posedge clk_sys);
    mask_wr_en <= 6'h3F;
    @(posedge clk_sys);
    mask_wr_en <= 6'h00;
    cyc(2);
    foreach (tab[i]) begin
      ev({tab[i][31:24], tab[i][7:0]}, {tab[i][47:40], tab[i][23:16]});
      chk("latched", tab[i], latched_status_flat);
      chk("pin", 1'b0, irq_n);
      chk("summary", {|tab[i][47:24], |tab[i][23:0]}, channel_pending_regs);
      clr(tab[i]);
      chk("pin idle", 1'b1, irq_n);
    end
    ev(16'h0000, 16'h0003);
    clr(48'h10000);
    chk("summary held", 2'b01, channel_pending_regs);
    chk("pin held", 1'b0, irq_n);
    gw(8'h03);
    chk("global mask", 1'b1, irq_n);
    gw(8'h01);
    clr(48'h20000);
    chk("summary off", 2'b00, channel_pending_regs);
    lv(16'h0008, 16'h0020);
    chk("live", 16'h0020, live_status_flat);
    chk("rise", 48'h2008, latched_status_flat);
    clr(48'h2008);
    lv(16'h0000, 16'h0000);
    chk("fall ignored", 48'h0, latched_status_flat);
    @(posedge clk_sys);
    edge_select_reg <= 16'h0001;
    lv(16'h0000, 16'h0003);
    chk("inband rise", 48'h0300, latched_status_flat);
    clr(48'h0300);
    lv(16'h0000, 16'h0000);
    chk("inband fall", 48'h0300, latched_status_flat);
    clr(48'h0300);
    chk("tick masked", 1'b1, second_tick_latched);
    gw(8'h00);
    chk("tick pin", 1'b0, irq_n);
    @(posedge clk_sys);
    host_auto <= 1'b1;
    wt(0, 1'b1, 8);
    @(posedge clk_sys);
    host_auto <= 1'b0;
    wt(1, 1'b1, 25);
    gw(8'h01);
    chk("gcf written", 8'h01, global_config_reg);
    @(posedge clk_sys);
    chan_sw_reset <= 2'b10;
    @(posedge clk_sys);
    chan_sw_reset <= 2'b00;
    cyc(2);
    chk("chan reset", {24'hFFFFFF, 24'h0}, mask_flat);
    ev(16'h0000, 16'h0100);
    chk("chan masked latch", 48'h0100_0000_0000, latched_status_flat);
    chk("chan masked pin", 1'b1, irq_n);
    chk("chan masked summary", 2'b00, channel_pending_regs);
    @(posedge clk_sys);
    chan_sw_reset <= 2'b01;
    @(posedge clk_sys);
    chan_sw_reset <= 2'b00;
    cyc(2);
    chk("chan0 reset", '1, mask_flat);
    tally_and_finish();
  end
endmodule // line_unit_interrupt_aggregator_test
bind lia_top lia_checker #(.NCH(NCH)) u_lia_checker (
  .clk_sys(clk_sys), .rst(rst), .chan_sw_reset(chan_sw_reset), .live_in1(live_in1),
  .event_in2(event_in2), .clear_wr(clear_wr), .latched_status_flat(latched_status_flat),
  .mask_flat(mask_flat), .global_config_reg(global_config_reg),
  .second_tick_latched(second_tick_latched), .channel_pending_regs(channel_pending_regs),
  .irq_n(irq_n)
);
